// ---- logic/irs_readout_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module irs_readout_top import irs_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [0:ADDR_W-1] SHARED_ADDR_BUS,
  input wire logic ROW_ADDR_LOAD,
  input wire logic COL_ADDR_LOAD,
  input wire logic COL_SHIFT_CLK,
  input wire logic SIGNAL_SAMPLE,
  input wire logic ROW_RESET,
  input wire logic RESET_LEVEL_SAMPLE,
  input wire logic DUAL_SLOPE_ROW_CLEAR,
  input wire logic [DATA_W-1:0] PIX_SIG_LEVEL,
  input wire logic [DATA_W-1:0] PIX_RST_LEVEL,
  input wire logic ADC_CLK,
  input wire logic ADC_POWER_DOWN,
  input wire logic ADC_OUT_ENABLE,
  output logic [ADDR_W-1:0] ROW_SELECT,
  output logic ROW_CONNECTED,
  output logic ROW_IN_RESET,
  output logic ROW_LEVELS_READY,
  output logic SEQ_ERROR,
  output logic [ADDR_W-1:0] COL_SELECT,
  output logic [DATA_W-1:0] ANALOG_OUT,
  output logic ANALOG_VALID,
  output logic [1:0] PIXEL_COLOR,
  output logic [DATA_W-1:0] PIXEL_CODE_OUT,
  output logic PIXEL_CODE_OE,
  output logic PIXEL_CODE_VALID
);
  irs_adc_if conv ();
  irs_seq_t state;
  irs_seq_t next_state;
  logic prev_row_ld, prev_col_ld, prev_shift, prev_s, prev_rst, prev_r;
  logic [ADDR_W-1:0] col_addr;
  logic col_loaded;
  logic [1:0] pv;
  logic [DATA_W-1:0] diff_stage;
  logic [1:0] color_stage;
  logic [1:0] edge_cnt;

  // pin 0 of the bus is the msb, so the vector maps straight across
  wire [ADDR_W-1:0] bus_addr = SHARED_ADDR_BUS;
  wire row_ld_rise = ROW_ADDR_LOAD & ~prev_row_ld;
  wire col_ld_rise = COL_ADDR_LOAD & ~prev_col_ld;
  wire shift_rise = COL_SHIFT_CLK & ~prev_shift;
  wire s_rise = SIGNAL_SAMPLE & ~prev_s;
  wire s_fall = ~SIGNAL_SAMPLE & prev_s;
  wire rst_rise = ROW_RESET & ~prev_rst;
  wire rst_fall = ~ROW_RESET & prev_rst;
  wire r_rise = RESET_LEVEL_SAMPLE & ~prev_r;
  wire r_fall = ~RESET_LEVEL_SAMPLE & prev_r;
  // levels stand in for the column amp of the selected column; no per-column store
  wire [DATA_W-1:0] next_diff = (PIX_RST_LEVEL > PIX_SIG_LEVEL) ?
    PIX_RST_LEVEL - PIX_SIG_LEVEL : DATA_RST;
  // even row and even column is red
  wire [1:0] next_color = (ROW_SELECT[0] == COL_SELECT[0]) ?
    (ROW_SELECT[0] ? COLOR_BLUE : COLOR_RED) : COLOR_GREEN;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prev_row_ld <= 1'b0;
      prev_col_ld <= 1'b0;
      prev_shift <= 1'b0;
      prev_s <= 1'b0;
      prev_rst <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      prev_row_ld <= ROW_ADDR_LOAD;
      prev_col_ld <= COL_ADDR_LOAD;
      prev_shift <= COL_SHIFT_CLK;
      prev_s <= SIGNAL_SAMPLE;
      prev_rst <= ROW_RESET;
      prev_r <= RESET_LEVEL_SAMPLE;
    end
  end

  // latch row address and connect row
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ROW_SELECT <= ADDR_RST;
      ROW_CONNECTED <= 1'b0;
      ROW_IN_RESET <= 1'b0;
    end else begin
      if (row_ld_rise) begin
        ROW_SELECT <= bus_addr;
        ROW_CONNECTED <= 1'b1;
      end
      // either reset input clears the addressed row
      ROW_IN_RESET <= ROW_RESET | DUAL_SLOPE_ROW_CLEAR;
    end
  end

  // walk the sample, reset, reference order
  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: next_state = SEQ_IDLE;
      SEQ_WAIT: if (s_rise) next_state = SEQ_SIG;
      SEQ_SIG: if (s_fall) next_state = SEQ_AFTER_SIG;
      SEQ_AFTER_SIG: if (rst_rise) next_state = SEQ_RST;
      SEQ_RST: if (rst_fall) next_state = SEQ_AFTER_RST;
      SEQ_AFTER_RST: if (r_rise) next_state = SEQ_REF;
      SEQ_REF: if (r_fall) next_state = SEQ_DONE;
      SEQ_DONE: next_state = SEQ_DONE;
      default: next_state = SEQ_IDLE;
    endcase
    if (row_ld_rise) next_state = SEQ_WAIT;
  end

  // pulses outside the expected slot; a reset in DONE is allowed for other rows
  wire out_of_order = (state == SEQ_WAIT && (rst_rise || r_rise)) ||
    (state == SEQ_AFTER_SIG && (s_rise || r_rise)) ||
    (state == SEQ_AFTER_RST && (s_rise || rst_rise));

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state <= SEQ_IDLE;
      ROW_LEVELS_READY <= 1'b0;
      SEQ_ERROR <= 1'b0;
    end else begin
      state <= next_state;
      ROW_LEVELS_READY <= (next_state == SEQ_DONE);
      // set wins over the clear by a new row load
      if (out_of_order) begin
        SEQ_ERROR <= 1'b1;
      end else if (row_ld_rise) begin
        SEQ_ERROR <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      col_addr <= ADDR_RST;
      col_loaded <= 1'b0;
    end else if (col_ld_rise) begin
      col_addr <= bus_addr;
      col_loaded <= 1'b1;
    end
  end

  // shift clock loads column and subtracts levels
  // three-stage pipe to the analog output
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      COL_SELECT <= ADDR_RST;
      pv <= 2'h0;
      diff_stage <= DATA_RST;
      color_stage <= COLOR_RED;
      ANALOG_OUT <= DATA_RST;
      ANALOG_VALID <= 1'b0;
      PIXEL_COLOR <= COLOR_RED;
    end else if (shift_rise) begin
      COL_SELECT <= col_addr;
      pv <= {pv[0], col_loaded};
      diff_stage <= next_diff;
      color_stage <= next_color;
      ANALOG_OUT <= diff_stage;
      ANALOG_VALID <= pv[1];
      PIXEL_COLOR <= color_stage;
    end
  end

  // converter sees the pipe output; sampled level is only meaningful while valid
  assign conv.level = ANALOG_OUT;
  assign conv.conv_clk = ADC_CLK;
  assign conv.power_down = ADC_POWER_DOWN;
  assign conv.out_enable = ADC_OUT_ENABLE;

  irs_adc u_adc (
    .clk(CLK),
    .rst_b(RST_B),
    .conv(conv)
  );

  assign PIXEL_CODE_OUT = conv.code;
  assign PIXEL_CODE_OE = conv.code_oe;
  assign PIXEL_CODE_VALID = conv.code_valid;

  // helper: shift rises seen since the first column load, held at three
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      edge_cnt <= 2'h0;
    end else if (shift_rise && col_loaded && edge_cnt != PIPE_CNT_MAX) begin
      edge_cnt <= edge_cnt + 2'h1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  row_latch_a: assert property (row_ld_rise |=> (ROW_CONNECTED && ROW_SELECT == $past(bus_addr)))
    else $error("row address not latched on load strobe");
  levels_order_a: assert property ($rose(ROW_LEVELS_READY) |-> $past(state) == SEQ_REF)
    else $error("levels ready without completed reference sample");
  seq_error_a: assert property ((state == SEQ_WAIT && (rst_rise || r_rise) && !row_ld_rise) |=> SEQ_ERROR)
    else $error("reference sample before signal sample not flagged");
  col_capture_a: assert property (col_ld_rise |=> col_addr == $past(bus_addr))
    else $error("column address not captured on load rise");
  col_clock_a: assert property (shift_rise |=> COL_SELECT == $past(col_addr))
    else $error("column select not loaded by shift clock");
  pipe_third_a: assert property ($rose(ANALOG_VALID) |-> edge_cnt == PIPE_CNT_MAX)
    else $error("first pixel not at third shift clock rise");
  diff_path_a: assert property ((shift_rise && PIX_RST_LEVEL > PIX_SIG_LEVEL)
    |=> diff_stage == $past(PIX_RST_LEVEL) - $past(PIX_SIG_LEVEL))
    else $error("subtracted level lost in pipe");
  color_red_a: assert property ((shift_rise && !ROW_SELECT[0] && !COL_SELECT[0])
    |=> color_stage == COLOR_RED)
    else $error("even row and column not red");
  row_done_c: cover property (row_ld_rise ##[1:1000] $rose(ROW_LEVELS_READY));
  first_pixel_c: cover property ($rose(ANALOG_VALID));
  code_out_c: cover property (PIXEL_CODE_VALID && PIXEL_CODE_OE);
endmodule : irs_readout_top
`default_nettype wire

// ---- shared/irs_pkg.sv ----
// constants and types for the image row/column readout sequencer
package irs_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 10;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADC_VALID_NS = 20;
  // least time, rounded up to whole cycles
  localparam int ADC_VALID_CYC = (ADC_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIPE_DEPTH = 3;
  localparam logic [1:0] ADC_CNT_ONE = 2'h1;
  localparam logic [1:0] ADC_CNT_LOAD = ADC_VALID_CYC[1:0];
  localparam logic [1:0] PIPE_CNT_MAX = PIPE_DEPTH[1:0];
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 10'h000;
  localparam logic [1:0] COLOR_RED = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_BLUE = 2'h2;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_WAIT = 3'h1,
    SEQ_SIG = 3'h3,
    SEQ_AFTER_SIG = 3'h2,
    SEQ_RST = 3'h6,
    SEQ_AFTER_RST = 3'h7,
    SEQ_REF = 3'h5,
    SEQ_DONE = 3'h4
  } irs_seq_t;
endpackage : irs_pkg

// ---- shared/irs_adc_if.sv ----
// signals between the readout core and the on-chip converter
`timescale 1ns/100ps
`default_nettype none
interface irs_adc_if;
  import irs_pkg::*;
  logic [DATA_W-1:0] level;
  logic conv_clk;
  logic power_down;
  logic out_enable;
  logic [DATA_W-1:0] code;
  logic code_valid;
  logic code_oe;
  modport core (output level, output conv_clk, output power_down, output out_enable,
    input code, input code_valid, input code_oe);
  modport adc (input level, input conv_clk, input power_down, input out_enable,
    output code, output code_valid, output code_oe);
endinterface : irs_adc_if
`default_nettype wire

// ---- logic/irs_adc.sv ----
// on-chip 10-bit converter with tri-state output control
`timescale 1ns/100ps
`default_nettype none
module irs_adc import irs_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  irs_adc_if.adc conv
);
  logic prev_clk;
  logic [1:0] cnt;
  logic [DATA_W-1:0] sample;
  wire fall = prev_clk & ~conv.conv_clk;
  wire start = fall & ~conv.power_down;
  wire present = (cnt == ADC_CNT_ONE) & ~conv.power_down;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_clk <= 1'b0;
      cnt <= 2'h0;
      sample <= DATA_RST;
    end else begin
      prev_clk <= conv.conv_clk;
      if (start) begin
        sample <= conv.level;
        cnt <= ADC_CNT_LOAD;
      end else if (conv.power_down) begin
        cnt <= 2'h0;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - ADC_CNT_ONE;
      end
    end
  end

  // bit zero is the least significant
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv.code <= DATA_RST;
      conv.code_valid <= 1'b0;
    end else if (conv.power_down) begin
      conv.code <= DATA_RST;
      conv.code_valid <= 1'b0;
    end else if (present) begin
      conv.code <= sample;
      conv.code_valid <= 1'b1;
    end else if (start) begin
      conv.code_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv.code_oe <= 1'b0;
    end else begin
      conv.code_oe <= conv.out_enable & ~conv.power_down;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // result registers one edge after the start edge, so it is seen two edges on
  conv_time_a: assert property ((start ##1 !conv.power_down) |=> (conv.code_valid && conv.code == $past(conv.level, 2)))
    else $error("conversion result not presented one cycle after falling edge");
  power_quiet_a: assert property (conv.power_down |=> (!conv.code_valid && !conv.code_oe))
    else $error("converter active while powered down");
  out_disable_a: assert property (!conv.out_enable |=> !conv.code_oe)
    else $error("output drivers on while disabled");
  conv_done_c: cover property (start ##2 conv.code_valid);
endmodule : irs_adc
`default_nettype wire

// ---- bench/irs_ctl_model.sv ----
// behavioural image controller driving the shared address bus and strobes
`timescale 1ns/100ps
`default_nettype none
module irs_ctl_model import irs_pkg::*; (
  input wire logic clk,
  output var logic [0:ADDR_W-1] bus,
  output var logic row_ld,
  output var logic col_ld,
  output wire logic shift_clk,
  output var logic sig_s,
  output var logic row_rst,
  output var logic ref_s,
  output wire logic ds_clr
);
  logic [1:0] shift_cnt = 2'h0;
  initial begin
    bus = '0;
    row_ld = 1'b0;
    col_ld = 1'b0;
    sig_s = 1'b0;
    row_rst = 1'b0;
    ref_s = 1'b0;
  end
  always @(posedge clk) shift_cnt <= #1 shift_cnt + 2'h1;
  assign shift_clk = shift_cnt[1];
  assign ds_clr = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // msb on index 0, row first
  task automatic row_seq(input logic [ADDR_W-1:0] a, input bit bad);
    bus = a;
    row_ld = 1'b1;
    tick(2);
    row_ld = 1'b0;
    if (bad) begin
      row_rst = 1'b1;
      tick(8);
      row_rst = 1'b0;
      return;
    end
    // S falls 146 cycles after load
    tick(128);
    sig_s = 1'b1;
    tick(16);
    sig_s = 1'b0;
    // reset after S and load fall
    tick(4);
    row_rst = 1'b1;
    tick(8);
    row_rst = 1'b0;
    tick(50);
    ref_s = 1'b1;
    tick(16);
    bus = ~a;
    ref_s = 1'b0;
  endtask : row_seq
  // load on a shift rise, bench then waits three rises
  task automatic col_load(input logic [ADDR_W-1:0] c);
    @(posedge shift_clk);
    bus = c;
    col_ld = 1'b1;
    tick(2);
    col_ld = 1'b0;
    bus = ~c;
  endtask : col_load
endmodule : irs_ctl_model
`default_nettype wire

// ---- bench/irs_readout_top_bench.sv ----
// self-checking bench with a reference model for the readout top
`timescale 1ns/100ps
`default_nettype none
module irs_readout_top_bench import irs_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [DATA_W-1:0] sig_lvl = '0;
  logic [DATA_W-1:0] rst_lvl = '0;
  logic adc_clk = 1'b1;
  logic adc_pd = 1'b0;
  logic adc_oe = 1'b1;
  wire logic [0:ADDR_W-1] bus;
  wire logic row_ld, col_ld, shift_clk, sig_s, row_rst, ref_s, ds_clr;
  logic [ADDR_W-1:0] row_sel, col_sel, row, col;
  logic conn, in_rst, ready, seq_err, a_valid, c_oe, c_valid;
  logic [DATA_W-1:0] a_out, code, exp;
  logic [DATA_W-1:0] exp_q[$];
  logic [1:0] color, exp_color;
  logic [15:0] seed = 16'h5A58;
  int errors = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  irs_ctl_model u_ctl (.clk(clk), .bus(bus), .row_ld(row_ld), .col_ld(col_ld),
    .shift_clk(shift_clk), .sig_s(sig_s), .row_rst(row_rst), .ref_s(ref_s), .ds_clr(ds_clr));
  irs_readout_top u_dut (.CLK(clk), .RST_B(rst_b), .SHARED_ADDR_BUS(bus),
    .ROW_ADDR_LOAD(row_ld), .COL_ADDR_LOAD(col_ld), .COL_SHIFT_CLK(shift_clk),
    .SIGNAL_SAMPLE(sig_s), .ROW_RESET(row_rst), .RESET_LEVEL_SAMPLE(ref_s),
    .DUAL_SLOPE_ROW_CLEAR(ds_clr), .PIX_SIG_LEVEL(sig_lvl), .PIX_RST_LEVEL(rst_lvl),
    .ADC_CLK(adc_clk), .ADC_POWER_DOWN(adc_pd), .ADC_OUT_ENABLE(adc_oe),
    .ROW_SELECT(row_sel), .ROW_CONNECTED(conn), .ROW_IN_RESET(in_rst),
    .ROW_LEVELS_READY(ready), .SEQ_ERROR(seq_err), .COL_SELECT(col_sel),
    .ANALOG_OUT(a_out), .ANALOG_VALID(a_valid), .PIXEL_COLOR(color),
    .PIXEL_CODE_OUT(code), .PIXEL_CODE_OE(c_oe), .PIXEL_CODE_VALID(c_valid));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    checked++;
    if (got !== want) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic want);
    checked++;
    if (got !== want) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_bit
  task automatic finish_test;
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // sequence needs some 950 cycles; limit leaves wide margin
  initial begin
    #(20000 * 25);
    errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(1);
    cmp_bit(conn, 1'b0);
    u_ctl.row_seq(10'h155, 1'b1);
    cmp_bit(in_rst, 1'b1);
    tick(2);
    cmp_bit(in_rst, 1'b0);
    cmp_bit(seq_err, 1'b1);
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      row = (r < 2) ? 10'(r) : seed[9:0];
      u_ctl.row_seq(row, 1'b0);
      cmp_bit(ready, 1'b0);
      tick(1);
      cmp_bit(ready, 1'b1);
      cmp_bit(seq_err, 1'b0);
      cmp_word(row_sel, row);
      cmp_bit(conn, 1'b1);
      for (int c = 0; c < 4; c++) begin
        seed = lfsr(seed);
        col = (c < 2) ? 10'(c) : seed[9:0];
        sig_lvl = seed[15:6];
        seed = lfsr(seed);
        rst_lvl = seed[9:0];
        exp_q.push_back((rst_lvl > sig_lvl) ? rst_lvl - sig_lvl : '0);
        u_ctl.col_load(col);
        repeat (3) @(posedge shift_clk);
        @(posedge clk);
        tick(1);
        exp = exp_q.pop_front();
        cmp_bit(a_valid, 1'b1);
        cmp_word(a_out, exp);
        cmp_word(col_sel, col);
        // even/even red, odd/odd blue, mixed green
        exp_color = (row[0] == col[0]) ? (row[0] ? COLOR_BLUE : COLOR_RED) : COLOR_GREEN;
        cmp_word({8'h00, color}, {8'h00, exp_color});
        adc_clk = 1'b0;
        tick(2);
        cmp_word(code, exp);
        cmp_bit(c_valid, 1'b1);
        cmp_bit(c_oe, 1'b1);
        adc_clk = 1'b1;
        tick(1);
      end
    end
    // power down must win over a conversion start
    adc_pd = 1'b1;
    adc_clk = 1'b0;
    tick(2);
    cmp_bit(c_oe, 1'b0);
    cmp_bit(c_valid, 1'b0);
    cmp_word(code, '0);
    adc_pd = 1'b0;
    adc_clk = 1'b1;
    adc_oe = 1'b0;
    tick(2);
    cmp_bit(c_oe, 1'b0);
    finish_test;
  end
endmodule : irs_readout_top_bench
`default_nettype wire
